// *** hw/ddcbf_top.v ***
// Behaviour
// - Channel picks any converter or test source
// - Bank runs as FIFO or one-shot capture
// - Gate length sets gate-driven transfer length
// - Metadata: channel id, timestamp, length
// - Independent 32-bit tuning word per channel
// - Decimation 1 to 65536 per channel
// - Own loadable 18-bit coefficients per channel
// - Default coefficients give 80 percent passband
// - Complex output, 24 or 16 bit
// - Phase and gain correction before meter
// - Power averaged over window up to 8K
// - Averaged power readable per channel
// - Interrupt on power above or below threshold
// - Summer adds any subset of outputs
// - Gain stage after summer offsets growth
// - Summer has own meter and threshold
// - Summed stream feeds channel one FIFO
// - Summer chains to other boards
// - Timing bus: clock, two syncs, two gates
// - Sample clock path: direct, synth, oscillator
// - Slave takes timing from the bus
// - Master drives timing onto the bus
`timescale 1ns/1ns
`include "ddcbf_map.vh"
module ddcbf_top (
  // Clock, reset, enable
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  // Converter samples, 16 bits per converter
  input  wire [63:0]  adc_data,
  // Channel configuration
  input  wire [11:0]  src_sel,
  input  wire [127:0] tune_word,
  input  wire [63:0]  decim_m1,
  input  wire [3:0]   fmt16,
  input  wire         coef_wr,
  input  wire [1:0]   coef_ch,
  input  wire [2:0]   coef_tap,
  input  wire [17:0]  coef_data,
  input  wire [63:0]  gain_i,
  input  wire [63:0]  gain_q,
  input  wire [63:0]  phase_adj,
  input  wire [15:0]  win_log2,
  input  wire [191:0] thresh,
  input  wire [3:0]   flag_clr,
  input  wire [3:0]   oneshot,
  input  wire [3:0]   arm,
  // Summer configuration and chain input
  input  wire [3:0]   bf_mask,
  input  wire [15:0]  bf_gain,
  input  wire         bf_to_ch1,
  input  wire [3:0]   bf_win,
  input  wire [47:0]  bf_thresh,
  input  wire         bf_clr,
  input  wire         chain_en,
  input  wire         chain_valid,
  input  wire [25:0]  chain_i,
  input  wire [25:0]  chain_q,
  // Timing
  input  wire         master,
  input  wire [1:0]   clk_src_sel,
  input  wire [1:0]   loc_sync,
  input  wire [1:0]   loc_gate,
  input  wire [1:0]   bus_sync_in,
  input  wire [1:0]   bus_gate_in,
  // Acquisition streams and metadata
  output wire [95:0]  acq_i,
  output wire [95:0]  acq_q,
  output wire [3:0]   acq_valid,
  output wire [3:0]   meta_valid,
  output wire [7:0]   meta_chan,
  output wire [127:0] meta_ts,
  output wire [127:0] meta_len,
  output wire [3:0]   cap_done,
  // Channel meters
  output wire [191:0] ch_power,
  output wire [3:0]   ch_over,
  output wire [3:0]   ch_under,
  output wire [3:0]   ch_irq,
  // Summer meter and chain output
  output wire [47:0]  bf_power,
  output wire         bf_over,
  output wire         bf_under,
  output wire         bf_irq,
  output reg          chain_out_valid,
  output reg  [25:0]  chain_out_i,
  output reg  [25:0]  chain_out_q,
  // Timing bus and clock path
  output reg  [1:0]   clk_path,
  output reg          tbus_clk_oe_n,
  output reg  [1:0]   tbus_sync_out,
  output reg          tbus_sync_oe_n,
  output reg  [1:0]   tbus_gate_out,
  output reg          tbus_gate_oe_n
);
  reg  [17:0] coef_mem [0:31];
  reg  [15:0] tp_r;
  reg  [31:0] ts_r;
  reg  [1:0]  sync_r;
  reg  [1:0]  gate_r;
  reg         gate_d;
  reg  [23:0] bf_i_r;
  reg  [23:0] bf_q_r;
  reg         bf_v_r;
  reg  [25:0] s_i;
  reg  [25:0] s_q;
  wire [95:0] ci_all;
  wire [95:0] cq_all;
  wire [3:0]  cv_all;
  wire        gate_rise = gate_r[0] & ~gate_d;
  wire        gate_fall = ~gate_r[0] & gate_d;
  wire signed [41:0] bpi = $signed(s_i) * $signed(bf_gain);
  wire signed [41:0] bpq = $signed(s_q) * $signed(bf_gain);
  integer j;
  integer m;

  function [15:0] cosl;
    input [2:0] a;
    begin
      case (a)
        3'h0:    cosl = 16'h7FFF;
        3'h1:    cosl = 16'h5A82;
        3'h2:    cosl = 16'h0000;
        3'h3:    cosl = 16'hA57E;
        3'h4:    cosl = 16'h8001;
        3'h5:    cosl = 16'hA57E;
        3'h6:    cosl = 16'h0000;
        default: cosl = 16'h5A82;
      endcase
    end
  endfunction

  function [17:0] coef_def;
    input [2:0] t;
    begin
      case (t)
        3'h0, 3'h7: coef_def = `DDCBF_COEF0;
        3'h1, 3'h6: coef_def = `DDCBF_COEF1;
        3'h2, 3'h5: coef_def = `DDCBF_COEF2;
        default:    coef_def = `DDCBF_COEF3;
      endcase
    end
  endfunction

  // Timing bus, test pattern, timestamp, coefficient store
  always @(posedge clk) begin
    if (!rst_n) begin
      tp_r           <= 16'h0000;
      ts_r           <= 32'h0;
      sync_r         <= 2'h0;
      gate_r         <= 2'h0;
      gate_d         <= 1'b0;
      clk_path       <= `DDCBF_CLK_EXT;
      tbus_clk_oe_n  <= 1'b1;
      tbus_sync_out  <= 2'h0;
      tbus_sync_oe_n <= 1'b1;
      tbus_gate_out  <= 2'h0;
      tbus_gate_oe_n <= 1'b1;
      for (j = 0; j < 32; j = j + 1)
        coef_mem[j] <= coef_def(j[2:0]);
    end else if (ce) begin
      tp_r           <= tp_r + 16'h0001;
      clk_path       <= clk_src_sel;
      sync_r         <= master ? loc_sync : bus_sync_in;
      gate_r         <= master ? loc_gate : bus_gate_in;
      gate_d         <= gate_r[0];
      tbus_clk_oe_n  <= ~master;
      tbus_sync_oe_n <= ~master;
      tbus_gate_oe_n <= ~master;
      tbus_sync_out  <= loc_sync;
      tbus_gate_out  <= loc_gate;
      ts_r           <= sync_r[1] ? 32'h0 : ts_r + 32'h1;
      if (coef_wr)
        coef_mem[{coef_ch, coef_tap}] <= coef_data;
    end
  end

  // Summer with optional upstream partial sum
  always @* begin
    s_i = (chain_en & chain_valid) ? chain_i : 26'h0;
    s_q = (chain_en & chain_valid) ? chain_q : 26'h0;
    for (m = 0; m < 4; m = m + 1) begin
      if (bf_mask[m]) begin
        s_i = s_i + {{2{ci_all[24*m+23]}}, ci_all[24*m+:24]};
        s_q = s_q + {{2{cq_all[24*m+23]}}, cq_all[24*m+:24]};
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      bf_i_r          <= 24'h0;
      bf_q_r          <= 24'h0;
      bf_v_r          <= 1'b0;
      chain_out_valid <= 1'b0;
      chain_out_i     <= 26'h0;
      chain_out_q     <= 26'h0;
    end else if (ce) begin
      bf_v_r          <= |(bf_mask & cv_all);
      chain_out_valid <= |(bf_mask & cv_all);
      if (|(bf_mask & cv_all)) begin
        bf_i_r      <= bpi[`DDCBF_GAIN_SH+:24];
        bf_q_r      <= bpq[`DDCBF_GAIN_SH+:24];
        chain_out_i <= s_i;
        chain_out_q <= s_q;
      end
    end
  end

  ddcbf_pmeter u_bf_meter (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .in_valid (bf_v_r),
    .in_i     (bf_i_r),
    .in_q     (bf_q_r),
    .win_log2 (bf_win),
    .thresh   (bf_thresh),
    .flag_clr (bf_clr),
    .power    (bf_power),
    .over     (bf_over),
    .under    (bf_under),
    .irq      (bf_irq)
  );

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : ch
      localparam [1:0] CH_ID = c;
      reg  [15:0] x;
      reg  [31:0] ph_r;
      reg  [15:0] cnt_r;
      reg  [2:0]  tap_r;
      reg  [51:0] ai_r;
      reg  [51:0] aq_r;
      reg  [23:0] yi_r;
      reg  [23:0] yq_r;
      reg         yv_r;
      reg  [23:0] ci_r;
      reg  [23:0] cq_r;
      reg         cv_r;
      reg  [23:0] oi_r;
      reg  [23:0] oq_r;
      reg         ov_r;
      reg  [31:0] len_r;
      reg  [31:0] gts_r;
      reg  [31:0] ml_r;
      reg  [31:0] mt_r;
      reg         mv_r;
      reg         done_r;
      wire signed [15:0] co = cosl(ph_r[31:29]);
      wire signed [15:0] sn = cosl(ph_r[31:29] - 3'h2);
      wire signed [31:0] pi = $signed(x) * co;
      wire signed [31:0] pq = $signed(x) * sn;
      wire signed [15:0] mq = -pq[30:15];
      wire signed [17:0] k = coef_mem[c*8+tap_r];
      wire signed [33:0] ti = $signed(pi[30:15]) * k;
      wire signed [33:0] tq = mq * k;
      wire signed [51:0] sum_i = $signed(ai_r) + ti;
      wire signed [51:0] sum_q = $signed(aq_r) + tq;
      wire last = (cnt_r == decim_m1[16*c+:16]);
      wire [23:0] fi = fmt16[c] ? {{8{yi_r[23]}}, yi_r[23:8]} : yi_r;
      wire [23:0] fq = fmt16[c] ? {{8{yq_r[23]}}, yq_r[23:8]} : yq_r;
      wire signed [39:0] gi = $signed(fi) * $signed(gain_i[16*c+:16]);
      wire signed [39:0] gq = $signed(fq) * $signed(gain_q[16*c+:16])
                            + $signed(fi) * $signed(phase_adj[16*c+:16]);
      wire sv = (c == 0 && bf_to_ch1) ? bf_v_r : cv_r;
      wire [23:0] si = (c == 0 && bf_to_ch1) ? bf_i_r : ci_r;
      wire [23:0] sq = (c == 0 && bf_to_ch1) ? bf_q_r : cq_r;
      wire pass = gate_r[0] & ~(oneshot[c] & done_r);

      always @* begin
        case (src_sel[3*c+:3])
          3'h0:    x = adc_data[15:0];
          3'h1:    x = adc_data[31:16];
          3'h2:    x = adc_data[47:32];
          3'h3:    x = adc_data[63:48];
          default: x = tp_r;
        endcase
      end

      always @(posedge clk) begin
        if (!rst_n) begin
          ph_r  <= 32'h0;
          cnt_r <= 16'h0;
          tap_r <= 3'h0;
          ai_r  <= 52'h0;
          aq_r  <= 52'h0;
          yi_r  <= 24'h0;
          yq_r  <= 24'h0;
          yv_r  <= 1'b0;
          ci_r  <= 24'h0;
          cq_r  <= 24'h0;
          cv_r  <= 1'b0;
        end else if (ce) begin
          yv_r <= 1'b0;
          cv_r <= yv_r;
          if (yv_r) begin
            ci_r <= gi[`DDCBF_GAIN_SH+:24];
            cq_r <= gq[`DDCBF_GAIN_SH+:24];
          end
          if (sync_r[0]) begin
            ph_r  <= 32'h0;
            cnt_r <= 16'h0;
            tap_r <= 3'h0;
            ai_r  <= 52'h0;
            aq_r  <= 52'h0;
          end else begin
            ph_r <= ph_r + tune_word[32*c+:32];
            if (last) begin
              cnt_r <= 16'h0;
              tap_r <= 3'h0;
              ai_r  <= 52'h0;
              aq_r  <= 52'h0;
              yi_r  <= sum_i[`DDCBF_ACC_LSB+:24];
              yq_r  <= sum_q[`DDCBF_ACC_LSB+:24];
              yv_r  <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 16'h0001;
              tap_r <= tap_r + 3'h1;
              ai_r  <= sum_i;
              aq_r  <= sum_q;
            end
          end
        end
      end

      always @(posedge clk) begin
        if (!rst_n) begin
          oi_r   <= 24'h0;
          oq_r   <= 24'h0;
          ov_r   <= 1'b0;
          len_r  <= 32'h0;
          gts_r  <= 32'h0;
          ml_r   <= 32'h0;
          mt_r   <= 32'h0;
          mv_r   <= 1'b0;
          done_r <= 1'b0;
        end else if (ce) begin
          ov_r <= sv & pass;
          mv_r <= 1'b0;
          if (sv & pass) begin
            oi_r <= si;
            oq_r <= sq;
          end
          if (gate_rise) begin
            gts_r <= ts_r;
            len_r <= (sv & pass) ? 32'h1 : 32'h0;
          end else if (sv & pass) begin
            len_r <= len_r + 32'h1;
          end
          if (gate_fall & ~(oneshot[c] & done_r)) begin
            mv_r <= 1'b1;
            ml_r <= len_r;
            mt_r <= gts_r;
          end
          if (gate_fall & oneshot[c])
            done_r <= 1'b1;
          else if (arm[c])
            done_r <= 1'b0;
        end
      end

      ddcbf_pmeter u_meter (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .in_valid (cv_r),
        .in_i     (ci_r),
        .in_q     (cq_r),
        .win_log2 (win_log2[4*c+:4]),
        .thresh   (thresh[48*c+:48]),
        .flag_clr (flag_clr[c]),
        .power    (ch_power[48*c+:48]),
        .over     (ch_over[c]),
        .under    (ch_under[c]),
        .irq      (ch_irq[c])
      );

      assign ci_all[24*c+:24]    = ci_r;
      assign cq_all[24*c+:24]    = cq_r;
      assign cv_all[c]           = cv_r;
      assign acq_i[24*c+:24]     = oi_r;
      assign acq_q[24*c+:24]     = oq_r;
      assign acq_valid[c]        = ov_r;
      assign meta_valid[c]       = mv_r;
      assign meta_chan[2*c+:2]   = CH_ID;
      assign meta_ts[32*c+:32]   = mt_r;
      assign meta_len[32*c+:32]  = ml_r;
      assign cap_done[c]         = done_r;
    end
  endgenerate
endmodule

// *** hw/ddcbf_map.vh ***
`ifndef DDCBF_MAP_VH
`define DDCBF_MAP_VH
// Channel count and input source codes
`define DDCBF_NCH       4
`define DDCBF_SRC_TEST  3'h4
// Coefficient store
`define DDCBF_NTAP      8
`define DDCBF_COEF0     18'h02000
`define DDCBF_COEF1     18'h06000
`define DDCBF_COEF2     18'h0C000
`define DDCBF_COEF3     18'h10000
// Accumulator output lsb of the 24-bit result
`define DDCBF_ACC_LSB   17
// Gain and phase scaling, unity is 1 << 14
`define DDCBF_GAIN_SH   14
`define DDCBF_GAIN_ONE  16'h4000
// Power meter window, 2^13 = 8K samples at most
`define DDCBF_WIN_MAX   4'hD
// Sample clock paths
`define DDCBF_CLK_EXT   2'h0
`define DDCBF_CLK_SYN   2'h1
`define DDCBF_CLK_VCXO  2'h2
`define DDCBF_REF_MHZ   10
`endif

// *** hw/ddcbf_pmeter.v ***
`timescale 1ns/1ns
`include "ddcbf_map.vh"
module ddcbf_pmeter (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Sample stream
  input  wire        in_valid,
  input  wire [23:0] in_i,
  input  wire [23:0] in_q,
  // Configuration
  input  wire [3:0]  win_log2,
  input  wire [47:0] thresh,
  input  wire        flag_clr,
  // Results
  output reg  [47:0] power,
  output reg         over,
  output reg         under,
  output reg         irq
);
  reg  [60:0] acc_r;
  wire signed [47:0] ii = $signed(in_i) * $signed(in_i);
  wire signed [47:0] qq = $signed(in_q) * $signed(in_q);
  wire [48:0] e = {1'b0, ii} + {1'b0, qq};
  wire [3:0] w = (win_log2 > `DDCBF_WIN_MAX) ? `DDCBF_WIN_MAX : win_log2;
  wire [13:0] last_n = (14'h0001 << w) - 14'h0001;
  wire [60:0] sum = acc_r + {13'h0000, e[48:1]};
  wire [60:0] avg = sum >> w;
  reg  [13:0] n_r;
  reg         upd_r;
  reg         over_nxt;
  reg         under_nxt;

  always @* begin
    over_nxt  = (upd_r & (power > thresh)) | (over & ~flag_clr);
    under_nxt = (upd_r & (power < thresh)) | (under & ~flag_clr);
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= 61'h0;
      n_r   <= 14'h0;
      upd_r <= 1'b0;
      power <= 48'h0;
      over  <= 1'b0;
      under <= 1'b0;
      irq   <= 1'b0;
    end else if (ce) begin
      upd_r <= 1'b0;
      over  <= over_nxt;
      under <= under_nxt;
      irq   <= over_nxt | under_nxt;
      if (in_valid) begin
        if (n_r == last_n) begin
          power <= avg[47:0];
          acc_r <= 61'h0;
          n_r   <= 14'h0;
          upd_r <= 1'b1;
        end else begin
          acc_r <= sum;
          n_r   <= n_r + 14'h0001;
        end
      end
    end
  end
endmodule

// *** bench/ddcbf_adc_model.sv ***
`timescale 1ns/1ns
module ddcbf_adc_model (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Four converter words
  output reg  [63:0] adc_data
);
  reg [15:0] ph_r;
  initial ph_r = 16'h0000;
  initial adc_data = 64'h0;
  always @(posedge clk) begin
    ph_r <= rst_n ? ph_r + 16'h0111 : 16'h0000;
    // Distinct word per converter
    adc_data <= {ph_r ^ 16'h5A5A, ~ph_r, ph_r + 16'h1000, ph_r | 16'h4000};
  end
endmodule

// *** bench/ddcbf_sva.sv ***
`timescale 1ns/1ns
module ddcbf_sva (
  // Clock and control
  input wire       clk,
  input wire       rst_n,
  input wire       ce,
  input wire       master,
  input wire [1:0] clk_src_sel,
  input wire [1:0] loc_sync,
  input wire [1:0] loc_gate,
  input wire [3:0] flag_clr,
  // Design outputs
  input wire [3:0] meta_valid,
  input wire [7:0] meta_chan,
  input wire [3:0] ch_over,
  input wire [3:0] ch_under,
  input wire [3:0] ch_irq,
  input wire       bf_over,
  input wire       bf_under,
  input wire       bf_irq,
  input wire       chain_out_valid,
  input wire [1:0] clk_path,
  input wire       tbus_clk_oe_n,
  input wire       tbus_sync_oe_n,
  input wire [1:0] tbus_sync_out,
  input wire [1:0] tbus_gate_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_master: assert property (ce |=> tbus_clk_oe_n == !$past(master))
    else $error("bus clock enable does not follow master");
  a_slave_hiz: assert property (ce && !master |=> tbus_sync_oe_n)
    else $error("sync driven in slave mode");
  a_sync_copy: assert property (ce && master |=> tbus_sync_out == $past(loc_sync))
    else $error("sync out not a copy of local sync");
  a_gate_copy: assert property (ce && master |=> tbus_gate_out == $past(loc_gate))
    else $error("gate out not a copy of local gate");
  a_clk_path: assert property (ce |=> clk_path == $past(clk_src_sel))
    else $error("clock path does not follow select");
  a_irq_or: assert property (ch_irq == (ch_over | ch_under))
    else $error("channel irq differs from flags");
  a_bf_irq: assert property (bf_irq == (bf_over | bf_under))
    else $error("summer irq differs from flags");
  a_flag_sticky: assert property (ce |=> ($past(ch_over) & ~$past(flag_clr) & ~ch_over) == 4'h0)
    else $error("over flag dropped without clear");
  a_meta_chan: assert property (meta_valid[1] |-> meta_chan[3:2] == 2'h1)
    else $error("metadata channel id wrong");
  c_meta: cover property (meta_valid[0]);
  c_over: cover property ($rose(ch_over[0]));
  c_chain: cover property (chain_out_valid);
endmodule
bind ddcbf_top ddcbf_sva ddcbf_sva_inst (.clk, .rst_n, .ce, .master, .clk_src_sel, .loc_sync,
  .loc_gate, .flag_clr, .meta_valid, .meta_chan, .ch_over, .ch_under, .ch_irq, .bf_over,
  .bf_under, .bf_irq, .chain_out_valid, .clk_path, .tbus_clk_oe_n, .tbus_sync_oe_n,
  .tbus_sync_out, .tbus_gate_out);

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`include "ddcbf_map.vh"
module testbench;
  reg           clk, rst_n, ce, coef_wr, bf_to_ch1, bf_clr, chain_en, chain_valid, master;
  reg  [11:0]   src_sel;
  reg  [127:0]  tune_word;
  reg  [63:0]   decim_m1, gain_i, gain_q, phase_adj;
  reg  [3:0]    fmt16, flag_clr, oneshot, arm, bf_mask, bf_win;
  reg  [1:0]    coef_ch, clk_src_sel, loc_sync, loc_gate, bus_sync_in, bus_gate_in;
  reg  [2:0]    coef_tap;
  reg  [17:0]   coef_data;
  reg  [15:0]   win_log2, bf_gain;
  reg  [191:0]  thresh;
  reg  [47:0]   bf_thresh;
  reg  [25:0]   chain_i, chain_q;
  wire [63:0]   adc_data;
  wire [95:0]   acq_i, acq_q;
  wire [3:0]    acq_valid, meta_valid, cap_done, ch_over, ch_under, ch_irq;
  wire [7:0]    meta_chan;
  wire [127:0]  meta_ts, meta_len;
  wire [47:0]   bf_power;
  wire          bf_over, bf_under, bf_irq, chain_out_valid;
  wire          tbus_clk_oe_n, tbus_sync_oe_n, tbus_gate_oe_n;
  wire [25:0]   chain_out_i, chain_out_q;
  wire [1:0]    clk_path, tbus_sync_out, tbus_gate_out;
  wire [191:0]  pw;
  integer       bad_count, n_tests, acq_cnt, meta_cnt, ch_cnt, k, e;
  reg  [31:0]   ts_a, ts_p, len_a;
  ddcbf_adc_model ddcbf_adc_model_inst (.clk, .rst_n, .adc_data);
  ddcbf_top ddcbf_top_inst (.clk, .rst_n, .ce, .adc_data, .src_sel, .tune_word, .decim_m1,
    .fmt16, .coef_wr, .coef_ch, .coef_tap, .coef_data, .gain_i, .gain_q, .phase_adj, .win_log2,
    .thresh, .flag_clr, .oneshot, .arm, .bf_mask, .bf_gain, .bf_to_ch1, .bf_win, .bf_thresh,
    .bf_clr, .chain_en, .chain_valid, .chain_i, .chain_q, .master, .clk_src_sel, .loc_sync,
    .loc_gate, .bus_sync_in, .bus_gate_in, .acq_i, .acq_q, .acq_valid, .meta_valid, .meta_chan,
    .meta_ts, .meta_len, .cap_done, .ch_power(pw), .ch_over, .ch_under, .ch_irq, .bf_power,
    .bf_over, .bf_under, .bf_irq, .chain_out_valid, .chain_out_i, .chain_out_q, .clk_path,
    .tbus_clk_oe_n, .tbus_sync_out, .tbus_sync_oe_n, .tbus_gate_out, .tbus_gate_oe_n);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    if (acq_valid[0] === 1'b1) acq_cnt = acq_cnt + 1;
    if (chain_out_valid === 1'b1) ch_cnt = ch_cnt + 1;
    if (meta_valid[0] === 1'b1) begin
      meta_cnt = meta_cnt + 1;
      ts_a = meta_ts[31:0];
      len_a = meta_len[31:0];
    end
  end
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [255:0] what, input [127:0] exp, input [127:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task done(input [255:0] name);
    $display("Test %0s finished", name);
  endtask
  task gate_run(input integer len, input integer slave);
    begin
      acq_cnt = 0;
      meta_cnt = 0;
      loc_sync = 2'b01;
      step(1);
      loc_sync = 2'b00;
      if (slave) bus_gate_in = 2'b01;
      else loc_gate = 2'b01;
      step(len);
      loc_gate = 2'b00;
      bus_gate_in = 2'b00;
      step(8);
    end
  endtask
  task print_verdict;
    begin
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    {bad_count, n_tests, acq_cnt, meta_cnt, ch_cnt} = 0;
    {rst_n, coef_wr, bf_to_ch1, bf_clr, chain_en, chain_valid, master} = 7'h00;
    {flag_clr, oneshot, arm, clk_src_sel, loc_sync, loc_gate, bus_sync_in, bus_gate_in} = 0;
    ce = 1'b1;
    src_sel = 12'h840;
    tune_word = {32'h10000000, 32'h0, 32'h0, 32'h0};
    decim_m1 = {4{16'h0001}};
    {gain_i, gain_q} = {8{`DDCBF_GAIN_ONE}};
    phase_adj = {16'h0100, 48'h0};
    fmt16 = 4'h8;
    win_log2 = 16'h1111;
    thresh = {96'h0, 48'hFFFFFFFFFFFF, 48'h0};
    {coef_ch, coef_tap, coef_data} = {2'h3, 3'h0, `DDCBF_COEF3};
    {bf_mask, bf_win, bf_gain, bf_thresh} = {4'hF, 4'h1, `DDCBF_GAIN_ONE, 48'h0};
    {chain_i, chain_q} = {26'h0000100, 26'h0};
    step(3);
    chk("clk oe_n reset", 1, tbus_clk_oe_n);
    chk("clk_path reset", 0, clk_path);
    rst_n = 1'b1;
    coef_wr = 1'b1;
    master = 1'b1;
    step(1);
    coef_wr = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
      clk_src_sel = k;
      loc_sync = k;
      step(1);
      chk("clk_path", k, clk_path);
      chk("sync out", k, tbus_sync_out);
      chk("clk oe_n", 0, tbus_clk_oe_n);
      chk("sync oe_n", 0, tbus_sync_oe_n);
      chk("gate oe_n", 0, tbus_gate_oe_n);
    end
    done("timing master");
    for (k = 0; k < 3; k = k + 1) begin
      e = 2 << k;
      decim_m1 = {4{e[15:0] - 16'h1}};
      ts_p = ts_a;
      gate_run(96, 0);
      chk("decim rate", 1, acq_cnt >= 96 / e - 1 && acq_cnt <= 96 / e + 1);
      chk("meta count", 1, meta_cnt);
      chk("meta chan", 8'hE4, meta_chan);
      chk("gate length", acq_cnt, len_a);
      if (k > 0) chk("ts step", 105, ts_a - ts_p);
    end
    chk("ch0 over", 1, ch_over[0]);
    chk("ch1 under", 1, ch_under[1]);
    chk("power nonzero", 1, |pw[47:0]);
    done("gate decimation");
    thresh[47:0] = 48'hFFFFFFFFFFFF;
    step(20);
    chk("over sticky", 1, ch_over[0]);
    flag_clr = 4'h1;
    step(1);
    flag_clr = 4'h0;
    step(2);
    chk("over cleared", 0, ch_over[0]);
    done("meter flags");
    {chain_en, chain_valid, bf_to_ch1} = 3'h7;
    ch_cnt = 0;
    gate_run(40, 0);
    chk("chain out", 1, ch_cnt > 0);
    chk("bf over", 1, bf_over);
    chk("bf to ch1", 1, acq_cnt > 0);
    bf_to_ch1 = 1'b0;
    done("summer");
    oneshot = 4'h1;
    arm = 4'h1;
    step(1);
    arm = 4'h0;
    gate_run(30, 0);
    chk("cap done", 1, cap_done[0]);
    gate_run(30, 0);
    chk("no data after capture", 0, acq_cnt);
    arm = 4'h1;
    step(1);
    arm = 4'h0;
    step(1);
    chk("cap rearmed", 0, cap_done[0]);
    oneshot = 4'h0;
    done("one shot");
    master = 1'b0;
    step(1);
    chk("slave oe_n", 1, tbus_clk_oe_n);
    chk("slave sync oe_n", 1, tbus_sync_oe_n);
    chk("slave gate oe_n", 1, tbus_gate_oe_n);
    gate_run(40, 1);
    chk("slave meta", 1, meta_cnt);
    done("slave");
    print_verdict;
  end
endmodule
